/* File: pkg/pfs_pkg.sv */
// Constants and types for the port one and fast event pin function select block
package pfs_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] IDX_CTL0   = 6'h00;
    localparam logic [5:0] IDX_CTL1   = 6'h01;
    localparam logic [5:0] IDX_CTL2   = 6'h02;
    localparam logic [5:0] IDX_CTL3   = 6'h03;
    localparam logic [5:0] IDX_DUTY1  = 6'h04;
    localparam logic [5:0] IDX_DUTY2  = 6'h05;
    localparam logic [5:0] IDX_STATUS = 6'h06;
    localparam logic [5:0] IDX_MASK   = 6'h07;
    localparam logic [5:0] IDX_LEVELS = 6'h08;
    localparam logic [5:0] IDX_PORT   = 6'h0f;

    // ==========================================================
    // Control bit positions
    localparam int CTL0_IN0_LOAD  = 0;
    localparam int CTL0_IN1_LOAD  = 2;
    localparam int CTL0_TRST_A    = 3;
    localparam int CTL0_IN2_LOAD  = 4;
    localparam int CTL0_TRST_B    = 5;
    localparam int CTL0_IN3_LOAD  = 6;
    localparam int CTL0_TCLK_EN   = 7;
    localparam int CTL1_OUT4_EN   = 4;
    localparam int CTL1_OUT5_EN   = 6;
    localparam int CTL2_WAVE_FREQ = 2;
    localparam int CTL3_TCLK_OFF  = 0;
    localparam int CTL3_WAVE1_SEL = 2;
    localparam int CTL3_WAVE2_SEL = 3;
    localparam int WAVE1_PIN      = 3;
    localparam int WAVE2_PIN      = 4;

    // ==========================================================
    // Interrupt status bits
    localparam int ST_W    = 3;
    localparam int ST_IN0  = 0;
    localparam int ST_TRST = 1;
    localparam int ST_LOAD = 2;

    // Fast input edge interrupt identity
    localparam logic [4:0]  IN0_INT_NUM = 5'h04;
    localparam logic [15:0] IN0_VECTOR  = 16'h2008;

    // ==========================================================
    // Reset values
    localparam logic [7:0]      RST_PORT = 8'hff;
    localparam logic [7:0]      RST_IOC  = 8'h00;
    localparam logic [7:0]      RST_DUTY = 8'h00;
    localparam logic [ST_W-1:0] RST_MASK = 3'h0;

    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] ctl3;
    } pfs_ioc_type;

    typedef struct packed {
        logic [7:0] duty1;
        logic [7:0] duty2;
    } pfs_duty_type;

endpackage

/* File: rtl/pfs_pin_select.sv */
// Port one, fast event input and fast event output pin function select
`timescale 1ns/100ps
// Function
// - All eight port one pins are quasi-bidirectional, accessed through the port register, except pins 3 and 4 when set to pulse width output.
// - Pin 3 carries port bit 3, or pulse_width_out_1 when io_control_3 bit 2 set.
// - pulse_width_out_1 duty from pulse_width_out_1_duty_control, frequency from io_control_2 bit 2.
// - Pin 4 carries port bit 4, or pulse_width_out_2 when io_control_3 bit 3 set.
// - pulse_width_out_2 duty from pulse_width_out_2_duty_control, same frequency select bit.
// - Rising edge on fast_event_in_0 raises interrupt 4 unless masked.
// - io_control_0 bit 0 loads fast_event_in_0 events into the event FIFO.
// - Enabled timer-two reset clears timer 2 on each rising edge.
// - Timer-two reset on fast_event_in_0 needs io_control_0 bits 3 and 5.
// - io_control_0 bit 2 loads fast_event_in_1 events into the event FIFO.
// - fast_event_in_1 clocks timer 2 when io_control_0.7 set and io_control_3.0 clear.
// - io_control_1 bit 4 drives fast_event_out_4 onto its shared pin.
// - io_control_0 bit 4 loads shared pin events as fast_event_in_2.
// - Output and input functions of a shared pin may be active together.
// - io_control_1 bit 6 drives fast_event_out_5 onto its shared pin.
// - io_control_0 bit 6 loads shared pin events as fast_event_in_3.
// - fast_event_out_0 and _1 drive dedicated pins without alternate function.
module pfs_pin_select #(
    parameter int PWM_W = 8
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [7:0]  GENERAL_PORT_ONE_IN,
    output logic      [7:0]  GENERAL_PORT_ONE_OUT,
    output logic      [7:0]  GENERAL_PORT_ONE_OE,
    output logic      [7:0]  GENERAL_PORT_ONE_PULLUP,
    input  wire logic        FAST_EVENT_IN_0,
    input  wire logic        FAST_EVENT_IN_1,
    input  wire logic [1:0]  SHARED_PIN_IN,
    output logic      [1:0]  SHARED_PIN_OUT,
    output logic      [1:0]  SHARED_PIN_OE,
    input  wire logic [3:0]  FAST_EVENT_OUT_SRC,
    output logic      [1:0]  FAST_EVENT_OUT_PIN,
    output logic      [3:0]  FAST_EVENT_LOAD,
    output logic             TIMER2_RESET,
    output logic             TIMER2_CLOCK,
    output logic             IRQ
);

    // ==========================================================
    // Helpers
    function automatic logic idx_hit(input logic [7:0] addr, input logic [5:0] idx);
        idx_hit = (addr == {idx, 2'b00});
    endfunction

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction

    // ==========================================================
    // Pin synchronisers and edge history
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] prev;
    logic [11:0] next_sync1;
    logic [11:0] next_sync2;
    logic [11:0] next_prev;
    logic [3:0]  fast_rise;

    always_comb begin
        next_sync1 = {SHARED_PIN_IN, FAST_EVENT_IN_1, FAST_EVENT_IN_0, GENERAL_PORT_ONE_IN};
        next_sync2 = sync1;
        next_prev  = sync2;
        fast_rise  = sync2[11:8] & ~prev[11:8];
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sync1 <= 12'h000;
            sync2 <= 12'h000;
            prev  <= 12'h000;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev  <= next_prev;
        end
    end

    // ==========================================================
    // Register file and APB slave
    pfs_pkg::pfs_ioc_type   ioc;
    pfs_pkg::pfs_duty_type  duty;
    logic [7:0]             port;
    logic [pfs_pkg::ST_W-1:0] status;
    logic [pfs_pkg::ST_W-1:0] mask;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   irq;
    pfs_pkg::pfs_ioc_type   next_ioc;
    pfs_pkg::pfs_duty_type  next_duty;
    logic [7:0]             next_port;
    logic [pfs_pkg::ST_W-1:0] next_status;
    logic [pfs_pkg::ST_W-1:0] next_mask;
    logic [31:0]            next_prdata;
    logic                   next_pready;
    logic                   next_pslverr;
    logic                   next_irq;
    logic                   wr;
    logic                   mapped;
    logic [pfs_pkg::ST_W-1:0] st_set;
    logic [3:0]             load_en;
    logic                   trst_en;
    logic                   tclk_en;

    always_comb begin
        load_en = {ioc.ctl0[pfs_pkg::CTL0_IN3_LOAD], ioc.ctl0[pfs_pkg::CTL0_IN2_LOAD],
                   ioc.ctl0[pfs_pkg::CTL0_IN1_LOAD], ioc.ctl0[pfs_pkg::CTL0_IN0_LOAD]};
        trst_en = ioc.ctl0[pfs_pkg::CTL0_TRST_A] & ioc.ctl0[pfs_pkg::CTL0_TRST_B];
        tclk_en = ioc.ctl0[pfs_pkg::CTL0_TCLK_EN] & ~ioc.ctl3[pfs_pkg::CTL3_TCLK_OFF];
        st_set = '0;
        st_set[pfs_pkg::ST_IN0]  = fast_rise[0];
        st_set[pfs_pkg::ST_TRST] = fast_rise[0] & trst_en;
        st_set[pfs_pkg::ST_LOAD] = |(fast_rise & load_en);
        mapped = idx_hit(PADDR, pfs_pkg::IDX_CTL0) | idx_hit(PADDR, pfs_pkg::IDX_CTL1)
               | idx_hit(PADDR, pfs_pkg::IDX_CTL2) | idx_hit(PADDR, pfs_pkg::IDX_CTL3)
               | idx_hit(PADDR, pfs_pkg::IDX_DUTY1) | idx_hit(PADDR, pfs_pkg::IDX_DUTY2)
               | idx_hit(PADDR, pfs_pkg::IDX_STATUS) | idx_hit(PADDR, pfs_pkg::IDX_MASK)
               | idx_hit(PADDR, pfs_pkg::IDX_LEVELS) | idx_hit(PADDR, pfs_pkg::IDX_PORT);
        // Write lands at the completing edge only
        wr = PSEL & PENABLE & PWRITE & pready;
        next_ioc    = ioc;
        next_duty   = duty;
        next_port   = port;
        next_mask   = mask;
        next_status = status;
        if (wr && idx_hit(PADDR, pfs_pkg::IDX_CTL0)) begin
            next_ioc.ctl0 = PWDATA[7:0];
        end
        if (wr && idx_hit(PADDR, pfs_pkg::IDX_CTL1)) begin
            next_ioc.ctl1 = PWDATA[7:0];
        end
        if (wr && idx_hit(PADDR, pfs_pkg::IDX_CTL2)) begin
            next_ioc.ctl2 = PWDATA[7:0];
        end
        if (wr && idx_hit(PADDR, pfs_pkg::IDX_CTL3)) begin
            next_ioc.ctl3 = PWDATA[7:0];
        end
        if (wr && idx_hit(PADDR, pfs_pkg::IDX_DUTY1)) begin
            next_duty.duty1 = PWDATA[7:0];
        end
        if (wr && idx_hit(PADDR, pfs_pkg::IDX_DUTY2)) begin
            next_duty.duty2 = PWDATA[7:0];
        end
        if (wr && idx_hit(PADDR, pfs_pkg::IDX_PORT)) begin
            next_port = PWDATA[7:0];
        end
        if (wr && idx_hit(PADDR, pfs_pkg::IDX_MASK)) begin
            next_mask = PWDATA[pfs_pkg::ST_W-1:0];
        end
        // Write one to clear; a new event in the same cycle wins
        if (wr && idx_hit(PADDR, pfs_pkg::IDX_STATUS)) begin
            next_status = status & ~PWDATA[pfs_pkg::ST_W-1:0];
        end
        next_status = next_status | st_set;
        next_irq    = |(status & mask);
        // One wait state: data prepared while pready is low
        next_pready  = PSEL & PENABLE & ~pready;
        next_pslverr = PSEL & PENABLE & ~pready & ~mapped;
        next_prdata  = 32'h00000000;
        if (PSEL && PENABLE && !pready && !PWRITE) begin
            unique case (1'b1)
                idx_hit(PADDR, pfs_pkg::IDX_CTL0):   next_prdata = zext8(ioc.ctl0);
                idx_hit(PADDR, pfs_pkg::IDX_CTL1):   next_prdata = zext8(ioc.ctl1);
                idx_hit(PADDR, pfs_pkg::IDX_CTL2):   next_prdata = zext8(ioc.ctl2);
                idx_hit(PADDR, pfs_pkg::IDX_CTL3):   next_prdata = zext8(ioc.ctl3);
                idx_hit(PADDR, pfs_pkg::IDX_DUTY1):  next_prdata = zext8(duty.duty1);
                idx_hit(PADDR, pfs_pkg::IDX_DUTY2):  next_prdata = zext8(duty.duty2);
                idx_hit(PADDR, pfs_pkg::IDX_STATUS): next_prdata = zext8({5'h00, status});
                idx_hit(PADDR, pfs_pkg::IDX_MASK):   next_prdata = zext8({5'h00, mask});
                idx_hit(PADDR, pfs_pkg::IDX_LEVELS): next_prdata = zext8({4'h0, sync2[11:8]});
                idx_hit(PADDR, pfs_pkg::IDX_PORT):   next_prdata = zext8(sync2[7:0]);
                default:                             next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ioc     <= {pfs_pkg::RST_IOC, pfs_pkg::RST_IOC, pfs_pkg::RST_IOC, pfs_pkg::RST_IOC};
            duty    <= {pfs_pkg::RST_DUTY, pfs_pkg::RST_DUTY};
            port    <= pfs_pkg::RST_PORT;
            mask    <= pfs_pkg::RST_MASK;
            status  <= '0;
            irq     <= 1'b0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            ioc     <= next_ioc;
            duty    <= next_duty;
            port    <= next_port;
            mask    <= next_mask;
            status  <= next_status;
            irq     <= next_irq;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // ==========================================================
    // Pulse-width generators sharing one counter
    logic             div;
    logic [PWM_W-1:0] cnt;
    logic             wave1;
    logic             wave2;
    logic             next_div;
    logic [PWM_W-1:0] next_cnt;
    logic             next_wave1;
    logic             next_wave2;
    logic             tick;

    always_comb begin
        // Frequency select halves the counter rate
        tick       = ~ioc.ctl2[pfs_pkg::CTL2_WAVE_FREQ] | div;
        next_div   = ~div;
        next_cnt   = tick ? cnt + 1'b1 : cnt;
        next_wave1 = cnt < duty.duty1[PWM_W-1:0];
        next_wave2 = cnt < duty.duty2[PWM_W-1:0];
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            div   <= 1'b0;
            cnt   <= '0;
            wave1 <= 1'b0;
            wave2 <= 1'b0;
        end else begin
            div   <= next_div;
            cnt   <= next_cnt;
            wave1 <= next_wave1;
            wave2 <= next_wave2;
        end
    end

    // ==========================================================
    // Pin drive and event outputs
    logic [7:0] port_out;
    logic [7:0] port_oe;
    logic [7:0] port_pull;
    logic [1:0] sh_out;
    logic [1:0] sh_oe;
    logic [1:0] hso_pin;
    logic [3:0] load;
    logic       t2_reset;
    logic       t2_clock;
    logic [7:0] next_port_out;
    logic [7:0] next_port_oe;
    logic [7:0] next_port_pull;
    logic [1:0] next_sh_out;
    logic [1:0] next_sh_oe;
    logic [1:0] next_hso_pin;
    logic [3:0] next_load;
    logic       next_t2_reset;
    logic       next_t2_clock;
    logic [7:0] alt;
    logic [7:0] wave;

    always_comb begin
        alt  = 8'h00;
        wave = 8'h00;
        alt[pfs_pkg::WAVE1_PIN]  = ioc.ctl3[pfs_pkg::CTL3_WAVE1_SEL];
        alt[pfs_pkg::WAVE2_PIN]  = ioc.ctl3[pfs_pkg::CTL3_WAVE2_SEL];
        wave[pfs_pkg::WAVE1_PIN] = wave1;
        wave[pfs_pkg::WAVE2_PIN] = wave2;
        // Alternate function pins are plain push-pull outputs
        next_port_out  = (alt & wave) | (~alt & port);
        next_port_oe   = alt | ~port;
        next_port_pull = ~alt & port;
        // Shared pins keep their input path live while driven
        next_sh_out  = FAST_EVENT_OUT_SRC[3:2];
        next_sh_oe   = {ioc.ctl1[pfs_pkg::CTL1_OUT5_EN], ioc.ctl1[pfs_pkg::CTL1_OUT4_EN]};
        next_hso_pin = FAST_EVENT_OUT_SRC[1:0];
        next_load    = fast_rise & load_en;
        next_t2_reset = fast_rise[0] & trst_en;
        next_t2_clock = fast_rise[1] & tclk_en;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            port_out  <= pfs_pkg::RST_PORT;
            port_oe   <= ~pfs_pkg::RST_PORT;
            port_pull <= pfs_pkg::RST_PORT;
            sh_out   <= 2'h0;
            sh_oe    <= 2'h0;
            hso_pin  <= 2'h0;
            load     <= 4'h0;
            t2_reset <= 1'b0;
            t2_clock <= 1'b0;
        end else begin
            port_out  <= next_port_out;
            port_oe   <= next_port_oe;
            port_pull <= next_port_pull;
            sh_out   <= next_sh_out;
            sh_oe    <= next_sh_oe;
            hso_pin  <= next_hso_pin;
            load     <= next_load;
            t2_reset <= next_t2_reset;
            t2_clock <= next_t2_clock;
        end
    end

    assign PRDATA                  = prdata;
    assign PREADY                  = pready;
    assign PSLVERR                 = pslverr;
    assign GENERAL_PORT_ONE_OUT    = port_out;
    assign GENERAL_PORT_ONE_OE     = port_oe;
    assign GENERAL_PORT_ONE_PULLUP = port_pull;
    assign SHARED_PIN_OUT          = sh_out;
    assign SHARED_PIN_OE           = sh_oe;
    assign FAST_EVENT_OUT_PIN      = hso_pin;
    assign FAST_EVENT_LOAD         = load;
    assign TIMER2_RESET            = t2_reset;
    assign TIMER2_CLOCK            = t2_clock;
    assign IRQ                     = irq;

    // ==========================================================
    // Checks
    chk_port_write: assert property (
        @(posedge CLK) disable iff (RST)
        (wr && idx_hit(PADDR, pfs_pkg::IDX_PORT)) |=> (port == $past(PWDATA[7:0])))
        else $error("port register write lost");

    chk_wave1_pin: assert property (
        @(posedge CLK) disable iff (RST)
        ioc.ctl3[pfs_pkg::CTL3_WAVE1_SEL] |=> (port_oe[3] && port_out[3] == $past(wave1)))
        else $error("pin 3 not carrying first wave");

    chk_wave1_zero: assert property (
        @(posedge CLK) disable iff (RST)
        (duty.duty1 == 8'h00) [*2] |-> !wave1)
        else $error("first wave high with zero duty");

    chk_port4_pin: assert property (
        @(posedge CLK) disable iff (RST)
        !ioc.ctl3[pfs_pkg::CTL3_WAVE2_SEL] |=>
            (port_out[4] == $past(port[4]) && port_oe[4] == !$past(port[4])))
        else $error("pin 4 not carrying port bit");

    chk_pwm_shared: assert property (
        @(posedge CLK) disable iff (RST)
        (duty.duty1 == duty.duty2) |=> (wave1 == wave2))
        else $error("pwm outputs differ with equal duty");

    chk_in0_irq: assert property (
        @(posedge CLK) disable iff (RST)
        (fast_rise[0] && mask[pfs_pkg::ST_IN0]) |-> ##[1:3] IRQ)
        else $error("edge interrupt not raised");

    chk_in0_load: assert property (
        @(posedge CLK) disable iff (RST)
        (fast_rise[0] && !ioc.ctl0[pfs_pkg::CTL0_IN0_LOAD]) |=> !load[0])
        else $error("disabled input loaded an event");

    chk_t2_reset: assert property (
        @(posedge CLK) disable iff (RST)
        t2_reset |-> ($past(fast_rise[0]) && $past(ioc.ctl0[pfs_pkg::CTL0_TRST_A])
                      && $past(ioc.ctl0[pfs_pkg::CTL0_TRST_B])))
        else $error("timer reset without cause");

    chk_t2_clock: assert property (
        @(posedge CLK) disable iff (RST)
        (fast_rise[1] && ioc.ctl0[pfs_pkg::CTL0_TCLK_EN] && !ioc.ctl3[pfs_pkg::CTL3_TCLK_OFF])
        |=> t2_clock)
        else $error("timer clock edge lost");

    chk_out4_drive: assert property (
        @(posedge CLK) disable iff (RST)
        ##1 (sh_oe[0] == $past(ioc.ctl1[pfs_pkg::CTL1_OUT4_EN])))
        else $error("shared pin enable wrong");

    chk_dedicated_out: assert property (
        @(posedge CLK) disable iff (RST)
        ##1 (hso_pin == $past(FAST_EVENT_OUT_SRC[1:0])))
        else $error("dedicated output not following source");

    chk_quasi_low: assert property (
        @(posedge CLK) disable iff (RST)
        !port[0] |=> (port_oe[0] && !port_out[0] && !port_pull[0]))
        else $error("quasi pin not driving low");

endmodule

/* File: tb/pfs_pin_model.sv */
// Board model: pin resolution, pull-ups and event pulse drivers
`timescale 1ns/100ps
module pfs_pin_model (
    input  wire logic       clk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pullup,
    input  wire logic [7:0] ext_low,
    input  wire logic [1:0] ev_req,
    input  wire logic [1:0] sh_out,
    input  wire logic [1:0] sh_oe,
    input  wire logic [1:0] sh_ext,
    output logic      [7:0] pad_in,
    output logic            ev0,
    output logic            ev1,
    output logic      [1:0] sh_in
);
    logic [2:0] cnt0 = 3'h0;
    logic [2:0] cnt1 = 3'h0;
    logic       flip = 1'b0;

    // ==========================================================
    // Event pulses held four cycles
    always @(posedge clk) begin
        flip <= ~flip;
        if (ev_req[0]) cnt0 <= 3'h4;
        else if (cnt0 != 3'h0) cnt0 <= cnt0 - 3'h1;
        if (ev_req[1]) cnt1 <= 3'h4;
        else if (cnt1 != 3'h0) cnt1 <= cnt1 - 3'h1;
    end
    assign ev0 = (cnt0 != 3'h0);
    assign ev1 = (cnt1 != 3'h0);

    // ==========================================================
    // Pin levels; an undriven pin without pull-up toggles
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_low[i] ? 1'b0 :
                        pad_pullup[i] ? 1'b1 : flip;
        end
    end
    assign sh_in = (sh_oe & sh_out) | (~sh_oe & sh_ext);
endmodule

/* File: tb/pfs_pin_select_tb.sv */
// Self-checking bench for the pin function select block
`timescale 1ns/100ps
module pfs_pin_select_tb;
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, se, ev0, ev1, tmr_rst, tmr_clk, irq;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pu, v, e, ext_low = 8'h00;
    logic [1:0]  sh_in, sh_out, sh_oe, ev_pin, ev_req = 2'h0, sh_ext = 2'h0;
    logic [3:0]  ev_src = 4'h0, ev_load;
    logic [15:0] seed = 16'h0013;
    logic [7:0]  corner [4] = '{8'hff, 8'h28, 8'h08, 8'h80};
    int          err_count = 0;
    int          checked = 0;

    always #4 CLK = ~CLK;

    pfs_pin_select pfs_pin_select_i (.CLK(CLK), .RST(RST), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .GENERAL_PORT_ONE_IN(pin_in), .GENERAL_PORT_ONE_OUT(pin_out),
        .GENERAL_PORT_ONE_OE(pin_oe), .GENERAL_PORT_ONE_PULLUP(pin_pu),
        .FAST_EVENT_IN_0(ev0), .FAST_EVENT_IN_1(ev1), .SHARED_PIN_IN(sh_in),
        .SHARED_PIN_OUT(sh_out), .SHARED_PIN_OE(sh_oe),
        .FAST_EVENT_OUT_SRC(ev_src), .FAST_EVENT_OUT_PIN(ev_pin),
        .FAST_EVENT_LOAD(ev_load), .TIMER2_RESET(tmr_rst),
        .TIMER2_CLOCK(tmr_clk), .IRQ(irq));

    pfs_pin_model pfs_pin_model_i (.clk(CLK), .pad_out(pin_out), .pad_oe(pin_oe),
        .pad_pullup(pin_pu), .ext_low(ext_low), .ev_req(ev_req), .sh_out(sh_out),
        .sh_oe(sh_oe), .sh_ext(sh_ext), .pad_in(pin_in), .ev0(ev0), .ev1(ev1),
        .sh_in(sh_in));

    // ==========================================================
    // Helpers
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        @(posedge CLK);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge CLK);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check(1'b0, 1'b1, "bus wait");
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pwm_run(input logic f, input logic [7:0] d1, input logic [7:0] d2);
        int h1, h2;
        h1 = 0;
        h2 = 0;
        apb(1'b1, pfs_pkg::IDX_CTL2, {29'h0, f, 2'h0});
        apb(1'b1, pfs_pkg::IDX_DUTY1, {24'h0, d1});
        apb(1'b1, pfs_pkg::IDX_DUTY2, {24'h0, d2});
        apb(1'b1, pfs_pkg::IDX_CTL3, 32'h0c);
        repeat (256 << f) @(posedge CLK);
        repeat (512 << f) begin
            @(posedge CLK);
            h1 += int'(pin_out[3] & pin_oe[3]);
            h2 += int'(pin_out[4] & pin_oe[4]);
        end
        check({30'h0, pin_oe[4:3]}, 32'h3, "pwm select");
        check(h1, (d1 * 2) << f, "pulse_width_out_1 high count");
        check(h2, (d2 * 2) << f, "pulse_width_out_2 high count");
    endtask

    task automatic ev_run(input logic [7:0] c0, input logic [7:0] c1,
                          input logic [7:0] c3, input logic [7:0] m);
        int n[6];
        logic [2:0] st;
        n = '{default: 0};
        st = {|{c0[0], c0[2], c0[4], c0[6]}, c0[3] & c0[5], 1'b1};
        apb(1'b1, pfs_pkg::IDX_CTL0, {24'h0, c0});
        apb(1'b1, pfs_pkg::IDX_CTL1, {24'h0, c1});
        apb(1'b1, pfs_pkg::IDX_CTL3, {24'h0, c3});
        apb(1'b1, pfs_pkg::IDX_MASK, {24'h0, m});
        apb(1'b1, pfs_pkg::IDX_STATUS, 32'h7);
        for (int c = 0; c < 24; c++) begin
            @(posedge CLK);
            for (int k = 0; k < 4; k++) n[k] += int'(ev_load[k]);
            n[4] += int'(tmr_rst);
            n[5] += int'(tmr_clk);
            ev_req <= (c == 0) ? 2'b11 : 2'b00;
            ev_src[3:2] <= (c > 0 && c < 6) ? 2'b11 : 2'b00;
            // Driven shared pins rise only through the output unit
            sh_ext <= (c > 0 && c < 6) ? ~{c1[6], c1[4]} : 2'b00;
        end
        check({30'h0, sh_oe}, {30'h0, c1[6], c1[4]}, "shared oe");
        check(n[0], c0[0], "load 0");
        check(n[1], c0[2], "load 1");
        check(n[2], c0[4], "load 2");
        check(n[3], c0[6], "load 3");
        check(n[4], c0[3] & c0[5], "timer reset");
        check(n[5], c0[7] & ~c3[0], "timer clock");
        apb(1'b0, pfs_pkg::IDX_STATUS, 32'h0);
        check(rd, {29'h0, st}, "status");
        check(irq, |(st & m[2:0]), "irq level");
        apb(1'b1, pfs_pkg::IDX_STATUS, 32'h7);
        repeat (2) @(posedge CLK);
        check(irq, 1'b0, "irq cleared");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        @(negedge CLK);
        check({pin_out, pin_oe, pin_pu, 7'h0, irq}, 32'hff00ff00, "reset pins");
        for (int k = 0; k < 3; k++) begin
            v = rnd();
            e = rnd();
            apb(1'b1, pfs_pkg::IDX_PORT, {24'h0, v});
            repeat (2) @(negedge CLK);
            check({pin_oe, pin_pu, pin_out & ~v}, {~v, v, 8'h00}, "quasi pins");
            @(posedge CLK);
            ext_low <= e;
            repeat (4) @(posedge CLK);
            apb(1'b0, pfs_pkg::IDX_PORT, 32'h0);
            check(rd, {24'h0, v & ~e}, "port read");
        end
        sh_ext <= 2'b11;
        repeat (3) @(posedge CLK);
        apb(1'b0, pfs_pkg::IDX_LEVELS, 32'h0);
        check(rd, 32'h0000000c, "input levels");
        sh_ext <= 2'b00;
        $display("port test done");
        for (int k = 0; k < 8; k++) begin
            v = rnd();
            @(posedge CLK);
            ev_src[1:0] <= v[1:0];
            @(posedge CLK);
            @(negedge CLK);
            check(ev_pin, v[1:0], "dedicated out");
        end
        $display("dedicated output test done");
        pwm_run(1'b0, rnd(), 8'h00);
        pwm_run(1'b1, 8'hff, rnd());
        $display("pwm test done");
        for (int k = 0; k < 10; k++) begin
            v = (k < 4) ? corner[k] : rnd();
            ev_run(v, rnd() & 8'h50, rnd() & 8'h01, rnd() & 8'h07);
        end
        $display("event test done");
        apb(1'b1, 6'h09, {24'h0, rnd()});
        check(se, 1'b1, "unmapped write");
        apb(1'b0, 6'h09, 32'h0);
        check({rd[30:0], se}, 32'h1, "unmapped read");
        $display("register test done");
        conclude();
    end

    initial begin
        repeat (40000) @(posedge CLK);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
